// ===== hw/fault_status_config_regs.sv
// status, fault, warning, lock and strap configuration register bank
// assumes a protocol engine on clk presents whole words as single-cycle strobes
`timescale 1ns/1ps
module fault_status_config_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic adc_valid,
	input wire logic [7:0] adc_code,
	input wire logic enable_pin,
	input wire logic overvoltage_protection,
	input wire logic undervoltage_protection,
	input wire logic overcurrent_latch_event,
	input wire logic total_limit_one,
	input wire logic total_limit_two,
	input wire logic phase_current_over,
	input wire logic [3:0] ramp_strap_pin,
	input wire logic [3:0] oc_strap_pin,
	output logic alert,
	output logic [13:0] ramp_time_us,
	output logic [7:0] phase_limit_mv,
	output logic [3:0] latchoff_delay_ms,
	output logic [1:0] phase_limit_code,
	output logic [1:0] latchoff_delay_code
);
	logic enable_level;
	logic [4:0] event_level;
	logic phase_sync;
	logic [3:0] ramp_strap;
	logic [3:0] oc_strap;
	logic enable_rise;
	logic [3:0] ramp_code;
	logic [3:0] oc_code;

	logic [7:0] current_warn_limit;
	logic [7:0] fault_clear_mask;
	logic [7:0] current_readback;
	logic [1:0] summary_bits;
	logic [4:0] fault_bits;
	logic warn_flag;
	logic lock;
	logic [3:0] overcurrent_config;
	logic second_a_oc;
	logic second_b_oc;
	logic [4:0] event_prev;

	logic wr_ok;
	logic wr_open;
	logic [7:0] wbyte;
	logic [4:0] event_rise;
	logic [4:0] fault_set;
	logic [4:0] fault_clr;
	logic warn_set;
	logic sw_override;
	logic [3:0] next_oc;
	logic [7:0] next_rdata;

	// ramp time in microseconds for a ramp code
	function automatic logic [13:0] ramp_us(input logic [3:0] code);
		logic [13:0] steps;
		steps = {10'h000, code};
		if (code < regbank_pkg::RAMP_LONG_FIRST) begin
			ramp_us = 14'((steps + 14'd1) * regbank_pkg::RAMP_STEP_US);
		end else begin
			ramp_us = 14'((steps - 14'd5) * regbank_pkg::RAMP_LONG_STEP_US);
		end
	endfunction

	function automatic logic [7:0] phase_mv(input logic [1:0] code);
		case (code)
			2'h0: phase_mv = regbank_pkg::PHASE_MV_0;
			2'h1: phase_mv = regbank_pkg::PHASE_MV_1;
			2'h2: phase_mv = regbank_pkg::PHASE_MV_2;
			default: phase_mv = regbank_pkg::PHASE_MV_3;
		endcase
	endfunction

	function automatic logic [3:0] delay_ms(input logic [1:0] code);
		case (code)
			2'h0: delay_ms = regbank_pkg::DELAY_MS_0;
			2'h1: delay_ms = regbank_pkg::DELAY_MS_1;
			2'h2: delay_ms = regbank_pkg::DELAY_MS_2;
			default: delay_ms = regbank_pkg::DELAY_MS_3;
		endcase
	endfunction

	// lockable limit registers share one write gate
	function automatic logic lockable(input logic [7:0] addr);
		lockable = 1'b0;
		if (addr == regbank_pkg::ADDR_WARN_LIMIT) begin
			lockable = 1'b1;
		end else if (addr == regbank_pkg::ADDR_FAULT_MASK) begin
			lockable = 1'b1;
		end else if (addr == regbank_pkg::ADDR_OC_CONFIG) begin
			lockable = 1'b1;
		end else if (addr == regbank_pkg::ADDR_SECOND_A) begin
			lockable = 1'b1;
		end else if (addr == regbank_pkg::ADDR_SECOND_B) begin
			lockable = 1'b1;
		end
	endfunction

	pin_sync #(.WIDTH(15)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.pin({enable_pin, overvoltage_protection, undervoltage_protection,
			overcurrent_latch_event, total_limit_one, total_limit_two,
			phase_current_over, ramp_strap_pin, oc_strap_pin}),
		.level({enable_level, event_level[4], event_level[3], event_level[2],
			event_level[1], event_level[0], phase_sync, ramp_strap, oc_strap})
	);

	strap_capture u_strap (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.enable_level(enable_level),
		.ramp_strap(ramp_strap),
		.oc_strap(oc_strap),
		.enable_rise(enable_rise),
		.ramp_code(ramp_code),
		.oc_code(oc_code)
	);

	// only the low byte carries data; high byte is accepted and dropped
	assign wbyte = reg_wdata[7:0];
	assign wr_ok = ce & reg_wr;
	assign wr_open = wr_ok & ~(lock & lockable(reg_addr));

	// events are taken on their rising edge so a held level is one event
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			event_prev <= '0;
		end else if (ce) begin
			event_prev <= {event_level[4], event_level[3], event_level[2], event_level[1],
				phase_sync};
		end
	end
	// order: ov, uv, latch-off, total one, phase; total two handled below
	assign event_rise = {event_level[4], event_level[3], event_level[2], event_level[1],
		phase_sync} & ~event_prev;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			current_warn_limit <= regbank_pkg::RST_WARN_LIMIT;
			fault_clear_mask <= regbank_pkg::RST_ZERO;
			overcurrent_config <= regbank_pkg::RST_STRAP;
			second_a_oc <= 1'b0;
			second_b_oc <= 1'b0;
		end else if (wr_open) begin
			if (reg_addr == regbank_pkg::ADDR_WARN_LIMIT) begin
				current_warn_limit <= wbyte;
			end else if (reg_addr == regbank_pkg::ADDR_FAULT_MASK) begin
				fault_clear_mask <= {3'h0, wbyte[regbank_pkg::FAULT_BITS-1:0]};
			end else if (reg_addr == regbank_pkg::ADDR_OC_CONFIG) begin
				overcurrent_config <= wbyte[3:0];
			end else if (reg_addr == regbank_pkg::ADDR_SECOND_A) begin
				second_a_oc <= wbyte[regbank_pkg::BIT_SECOND_OC];
			end else if (reg_addr == regbank_pkg::ADDR_SECOND_B) begin
				second_b_oc <= wbyte[regbank_pkg::BIT_SECOND_OC];
			end
		end
	end

	// lock only falls with power-on reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock <= 1'b0;
		end else if (wr_ok && reg_addr == regbank_pkg::ADDR_LOCK
				&& wbyte[regbank_pkg::BIT_LOCK]) begin
			lock <= 1'b1;
		end
	end

	// set terms gated by the mask; set beats a same-cycle clear
	logic total_two_prev;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			total_two_prev <= 1'b0;
		end else if (ce) begin
			total_two_prev <= event_level[0];
		end
	end

	always_comb begin
		fault_set = '0;
		fault_set[regbank_pkg::BIT_TOTAL_ONE] = event_rise[1]
			& fault_clear_mask[regbank_pkg::BIT_TOTAL_ONE];
		fault_set[regbank_pkg::BIT_TOTAL_TWO] = event_level[0] & ~total_two_prev
			& fault_clear_mask[regbank_pkg::BIT_TOTAL_TWO];
		fault_set[regbank_pkg::BIT_PHASE] = event_rise[0]
			& fault_clear_mask[regbank_pkg::BIT_PHASE];
		fault_set[regbank_pkg::BIT_OV] = event_rise[4]
			& fault_clear_mask[regbank_pkg::BIT_OV];
		fault_set[regbank_pkg::BIT_UV] = event_rise[3]
			& fault_clear_mask[regbank_pkg::BIT_UV];
		fault_clr = '0;
		if (wr_open && reg_addr == regbank_pkg::ADDR_FAULT_MASK) begin
			fault_clr = wbyte[regbank_pkg::FAULT_BITS-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_bits <= '0;
		end else if (ce) begin
			fault_bits <= (fault_bits & ~fault_clr) | fault_set;
		end
	end

	// summary bits restart with each enable rise, a new power-up attempt
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			summary_bits <= '0;
		end else if (ce) begin
			summary_bits[1] <= (summary_bits[1] & ~enable_rise) | event_rise[4];
			summary_bits[0] <= (summary_bits[0] & ~enable_rise) | event_rise[2];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			current_readback <= regbank_pkg::RST_ZERO;
		end else if (ce && adc_valid) begin
			current_readback <= adc_code;
		end
	end

	// compare the fresh sample so the flag never lags the readback
	assign warn_set = adc_valid & (adc_code > current_warn_limit);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warn_flag <= 1'b0;
			alert <= 1'b0;
		end else if (ce) begin
			warn_flag <= (warn_flag & ~enable_rise) | warn_set;
			alert <= (warn_flag & ~enable_rise) | warn_set;
		end
	end

	assign sw_override = second_a_oc & second_b_oc;
	assign next_oc = sw_override ? overcurrent_config : oc_code;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_limit_code <= 2'h0;
			latchoff_delay_code <= 2'h0;
			phase_limit_mv <= regbank_pkg::PHASE_MV_0;
			latchoff_delay_ms <= regbank_pkg::DELAY_MS_0;
			ramp_time_us <= regbank_pkg::RAMP_STEP_US;
		end else if (ce) begin
			phase_limit_code <= next_oc[3:2];
			latchoff_delay_code <= next_oc[1:0];
			phase_limit_mv <= phase_mv(next_oc[3:2]);
			latchoff_delay_ms <= delay_ms(next_oc[1:0]);
			ramp_time_us <= ramp_us(ramp_code);
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr == regbank_pkg::ADDR_WARN_LIMIT) begin
			next_rdata = current_warn_limit;
		end else if (reg_addr == regbank_pkg::ADDR_SUMMARY) begin
			next_rdata = {2'h0, summary_bits, 4'h0};
		end else if (reg_addr == regbank_pkg::ADDR_FAULT_MASK) begin
			next_rdata = fault_clear_mask;
		end else if (reg_addr == regbank_pkg::ADDR_FAULT) begin
			next_rdata = {3'h0, fault_bits};
		end else if (reg_addr == regbank_pkg::ADDR_WARNING) begin
			next_rdata = {7'h00, warn_flag};
		end else if (reg_addr == regbank_pkg::ADDR_READBACK) begin
			next_rdata = current_readback;
		end else if (reg_addr == regbank_pkg::ADDR_LOCK) begin
			next_rdata = {7'h00, lock};
		end else if (reg_addr == regbank_pkg::ADDR_RAMP) begin
			next_rdata = {4'h0, ramp_code};
		end else if (reg_addr == regbank_pkg::ADDR_OC_STATUS) begin
			next_rdata = {4'h0, oc_code};
		end else if (reg_addr == regbank_pkg::ADDR_OC_CONFIG) begin
			next_rdata = {4'h0, overcurrent_config};
		end else if (reg_addr == regbank_pkg::ADDR_SECOND_A) begin
			next_rdata = {7'h00, second_a_oc};
		end else if (reg_addr == regbank_pkg::ADDR_SECOND_B) begin
			next_rdata = {7'h00, second_b_oc};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= {8'h00, next_rdata};
			end
		end
	end
endmodule

// ===== hw/pin_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			level <= '0;
		end else if (ce) begin
			meta <= pin;
			level <= meta;
		end
	end
endmodule

// ===== hw/regbank_pkg.sv
// constants for the fault, status and strap configuration register bank
// assumes a register port driven by a serial-bus protocol engine on clk
package regbank_pkg;
	localparam logic [7:0] ADDR_WARN_LIMIT = 8'h20;
	localparam logic [7:0] ADDR_SUMMARY = 8'h21;
	localparam logic [7:0] ADDR_FAULT_MASK = 8'h22;
	localparam logic [7:0] ADDR_FAULT = 8'h23;
	localparam logic [7:0] ADDR_WARNING = 8'h24;
	localparam logic [7:0] ADDR_READBACK = 8'h26;
	localparam logic [7:0] ADDR_LOCK = 8'h2A;
	localparam logic [7:0] ADDR_RAMP = 8'h2B;
	localparam logic [7:0] ADDR_OC_STATUS = 8'h2D;
	localparam logic [7:0] ADDR_OC_CONFIG = 8'h2E;
	localparam logic [7:0] ADDR_SECOND_A = 8'h46;
	localparam logic [7:0] ADDR_SECOND_B = 8'h47;

	localparam logic [7:0] RST_WARN_LIMIT = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [3:0] RST_STRAP = 4'h0;

	localparam int BIT_SUM_OV = 5;
	localparam int BIT_SUM_OC = 4;
	localparam int BIT_TOTAL_ONE = 4;
	localparam int BIT_TOTAL_TWO = 3;
	localparam int BIT_PHASE = 2;
	localparam int BIT_OV = 1;
	localparam int BIT_UV = 0;
	localparam int BIT_WARN = 0;
	localparam int BIT_LOCK = 0;
	localparam int BIT_SECOND_OC = 0;
	localparam int FAULT_BITS = 5;

	// ramp time table in microseconds
	localparam logic [13:0] RAMP_STEP_US = 14'd150;
	localparam logic [13:0] RAMP_LONG_STEP_US = 14'd1000;
	localparam logic [3:0] RAMP_LONG_FIRST = 4'h6;

	// per-phase limit in millivolts
	localparam logic [7:0] PHASE_MV_0 = 8'd65;
	localparam logic [7:0] PHASE_MV_1 = 8'd75;
	localparam logic [7:0] PHASE_MV_2 = 8'd100;
	localparam logic [7:0] PHASE_MV_3 = 8'd134;

	// latch-off delay in milliseconds
	localparam logic [3:0] DELAY_MS_0 = 4'd4;
	localparam logic [3:0] DELAY_MS_1 = 4'd6;
	localparam logic [3:0] DELAY_MS_2 = 4'd8;
	localparam logic [3:0] DELAY_MS_3 = 4'd10;
endpackage

// ===== hw/strap_capture.sv
// samples strap codes on each rising edge of the synchronised enable
// assumes enable and straps are already synchronised to clk
`timescale 1ns/1ps
module strap_capture (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic enable_level,
	input wire logic [3:0] ramp_strap,
	input wire logic [3:0] oc_strap,
	output logic enable_rise,
	output logic [3:0] ramp_code,
	output logic [3:0] oc_code
);
	logic enable_prev;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_prev <= 1'b0;
		end else if (ce) begin
			enable_prev <= enable_level;
		end
	end

	assign enable_rise = enable_level & ~enable_prev;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ramp_code <= regbank_pkg::RST_STRAP;
			oc_code <= regbank_pkg::RST_STRAP;
		end else if (ce && enable_rise) begin
			ramp_code <= ramp_strap;
			oc_code <= oc_strap;
		end
	end
endmodule

// ===== test/fault_status_config_regs_sva.sv
// port-level checks of the register bank
// assumes one clock domain, reset async active low
`timescale 1ns/1ps
module fsc_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic adc_valid,
	input wire logic [7:0] adc_code,
	input wire logic enable_pin,
	input wire logic alert,
	input wire logic [13:0] ramp_time_us,
	input wire logic [7:0] phase_limit_mv,
	input wire logic [3:0] latchoff_delay_ms,
	input wire logic [1:0] phase_limit_code,
	input wire logic [1:0] latchoff_delay_code
);
	logic [7:0] lim, rb;
	logic lk;
	logic [3:0] en_age;
	function automatic logic [7:0] mv_of(input logic [1:0] c);
		return c == 2'h0 ? 8'h41 : c == 2'h1 ? 8'h4B : c == 2'h2 ? 8'h64 : 8'h86;
	endfunction
	function automatic logic [13:0] rt_of(input logic [3:0] c);
		return c < 4'h6 ? 14'(150 * (c + 1)) : 14'(1000 * (c - 5));
	endfunction
	// shadow of the limit, honouring the lock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lim <= 8'hFF;
			lk <= 1'b0;
			rb <= 8'h00;
		end else if (ce) begin
			if (reg_wr && reg_addr == 8'h20 && !lk)
				lim <= reg_wdata[7:0];
			if (reg_wr && reg_addr == 8'h2A && reg_wdata[0])
				lk <= 1'b1;
			if (adc_valid)
				rb <= adc_code;
		end
	end
	// cycles since enable was last low; the clear lags by the synchroniser
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			en_age <= 4'h0;
		else if (!enable_pin)
			en_age <= 4'h0;
		else if (en_age != 4'hF)
			en_age <= en_age + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_sample;
		ce && adc_valid;
	endsequence
	sequence s_rd(logic [7:0] a);
		ce && reg_rd && reg_addr == a;
	endsequence
	chk_alert_set: assert property (s_sample ##0 adc_code > lim |=> alert)
		else $error("alert missed");
	chk_alert_quiet: assert property (!alert ##0 s_sample ##0 adc_code <= lim |=> !alert)
		else $error("alert without excess");
	chk_alert_hold: assert property ($fell(alert) |-> en_age < 4'h8)
		else $error("alert cleared without enable");
	chk_readback_value: assert property (s_rd(8'h26) ##0 !adc_valid |=> reg_rdata == {8'h00, rb})
		else $error("readback wrong");
	chk_limit_lock: assert property (s_rd(8'h20) |=> reg_rdata == {8'h00, lim})
		else $error("limit changed");
	chk_upper_zero: assert property (reg_rvalid |-> reg_rdata[15:8] == 8'h00)
		else $error("upper byte set");
	chk_unmapped_zero: assert property (s_rd(8'h25) |=> reg_rvalid && reg_rdata == 16'h0000)
		else $error("unmapped read nonzero");
	chk_phase_decode: assert property (phase_limit_mv == mv_of(phase_limit_code))
		else $error("phase limit decode");
	chk_delay_decode: assert property (latchoff_delay_ms == 4'h4 + {1'b0, latchoff_delay_code, 1'b0})
		else $error("delay decode");
	chk_ramp_decode: assert property (s_rd(8'h2B) |=> ramp_time_us == rt_of(reg_rdata[3:0]))
		else $error("ramp decode");
endmodule
bind fault_status_config_regs fsc_checker chk (.clk, .rst_b, .ce, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .adc_valid, .adc_code, .enable_pin, .alert,
	.ramp_time_us, .phase_limit_mv, .latchoff_delay_ms, .phase_limit_code, .latchoff_delay_code);

// ===== test/host_model.sv
// serial-bus host seen as whole-word strobes on the register port
// assumes the protocol engine turns each word into one strobe cycle
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [15:0] reg_wdata,
	output logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic [15:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] hi, input logic [7:0] lo);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = {hi, lo};
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// released lines show junk, not the last word
		reg_wdata = ~reg_wdata;
		reg_addr = ~a;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		ok = (reg_rvalid === 1'b1);
		d = reg_rdata;
	endtask
endmodule

// ===== test/test_fault_status_config_regs.sv
// self-checking bench for the status, fault and strap register bank
// assumes host_model drives the register port and the checker is bound
`timescale 1ns/1ps
module test_fault_status_config_regs;
	logic clk, rst_b, ce, adc_valid, enable_pin, reg_wr, reg_rd, reg_rvalid, alert;
	logic [7:0] adc_code, reg_addr, lim, fexp;
	logic [5:0] ev;
	logic [3:0] ramp_strap_pin, oc_strap_pin, oc, cfg;
	logic [15:0] reg_wdata, reg_rdata, rd_word;
	logic [13:0] ramp_time_us;
	logic [7:0] phase_limit_mv;
	logic [3:0] latchoff_delay_ms;
	logic [1:0] phase_limit_code, latchoff_delay_code;
	int n_mismatch = 0;
	int samples_checked = 0;
	bit ok;
	logic [7:0] zero_regs[10] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h26, 8'h2A, 8'h2B, 8'h2D,
		8'h2E, 8'h25};
	logic [7:0] fbit[6] = '{8'h02, 8'h01, 8'h00, 8'h10, 8'h08, 8'h04};
	fault_status_config_regs uut (.clk, .rst_b, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .reg_rvalid, .adc_valid, .adc_code, .enable_pin,
		.overvoltage_protection(ev[0]), .undervoltage_protection(ev[1]),
		.overcurrent_latch_event(ev[2]), .total_limit_one(ev[3]), .total_limit_two(ev[4]),
		.phase_current_over(ev[5]), .ramp_strap_pin, .oc_strap_pin, .alert, .ramp_time_us,
		.phase_limit_mv, .latchoff_delay_ms, .phase_limit_code, .latchoff_delay_code);
	host_model u_host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rvalid, .reg_rdata);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [7:0] mv_of(input logic [1:0] c);
		return c == 2'h0 ? 8'h41 : c == 2'h1 ? 8'h4B : c == 2'h2 ? 8'h64 : 8'h86;
	endfunction
	function automatic logic [13:0] rt_of(input logic [3:0] c);
		return c < 4'h6 ? 14'(150 * (c + 1)) : 14'(1000 * (c - 5));
	endfunction
	task automatic complete_run();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd(a, rd_word, ok);
		if (!ok)
			rd_word = 16'hDEAD;
		chk_out(rd_word, {8'h00, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic sample(input logic [7:0] c);
		@(negedge clk);
		adc_code = c;
		adc_valid = 1'b1;
		@(negedge clk);
		adc_valid = 1'b0;
		adc_code = ~c;
		tick(1);
	endtask
	// pins go through two sync flops plus edge detect
	task automatic toggle_en();
		@(negedge clk);
		enable_pin = 1'b0;
		tick(4);
		enable_pin = 1'b1;
		tick(5);
	endtask
	task automatic pulse(input int i);
		@(negedge clk);
		ev[i] = 1'b1;
		tick(4);
		ev[i] = 1'b0;
		tick(2);
	endtask
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		adc_valid = 1'b0;
		adc_code = 8'h00;
		enable_pin = 1'b0;
		ev = 6'h00;
		ramp_strap_pin = 4'h0;
		oc_strap_pin = 4'h0;
		void'($urandom(32'h09D79832));
		tick(20);
		rst_b = 1'b1;
		chk_reg(8'h20, 8'hFF);
		foreach (zero_regs[i]) chk_reg(zero_regs[i], 8'h00);
		u_host.wr(8'h24, 8'h00, 8'hFF);
		u_host.wr(8'h25, 8'h00, 8'hFF);
		chk_reg(8'h24, 8'h00);
		chk_reg(8'h25, 8'h00);
		lim = 8'($urandom_range(8'hF0, 8'h10));
		u_host.wr(8'h20, 8'h00, lim);
		sample(lim);
		chk_out(alert, 1'b0);
		chk_reg(8'h26, lim);
		sample(lim + 8'h01);
		chk_out(alert, 1'b1);
		chk_reg(8'h24, 8'h01);
		sample(8'h00);
		u_host.wr(8'h20, 8'h00, 8'hFF);
		chk_reg(8'h24, 8'h01);
		sample(8'hFF);
		chk_reg(8'h26, 8'hFF);
		chk_out(alert, 1'b1);
		toggle_en();
		chk_out(alert, 1'b0);
		chk_reg(8'h24, 8'h00);
		for (int i = 0; i < 6; i++) pulse(i);
		chk_reg(8'h23, 8'h00);
		chk_reg(8'h21, 8'h30);
		u_host.wr(8'h22, 8'h00, 8'h1F);
		fexp = 8'h00;
		for (int i = 0; i < 6; i++) begin
			pulse(i);
			fexp = fexp | fbit[i];
			chk_reg(8'h23, fexp);
		end
		// a one-hot mask clears just its own fault bit
		for (int i = 0; i < 5; i++) begin
			u_host.wr(8'h22, 8'h00, 8'h01 << i);
			fexp = fexp & ~(8'h01 << i);
			chk_reg(8'h23, fexp);
		end
		for (int c = 0; c < 16; c++) begin
			oc = 4'($urandom);
			ramp_strap_pin = 4'(c);
			oc_strap_pin = oc;
			toggle_en();
			chk_reg(8'h2B, {4'h0, 4'(c)});
			chk_out(ramp_time_us, rt_of(4'(c)));
			chk_reg(8'h2D, {4'h0, oc});
			chk_out(phase_limit_mv, mv_of(oc[3:2]));
			chk_out(latchoff_delay_ms, 4'h4 + {oc[1:0], 1'b0});
		end
		u_host.wr(8'h2E, 8'h00, {4'h0, ~oc});
		u_host.wr(8'h46, 8'h00, 8'h01);
		tick(2);
		chk_out(phase_limit_code, oc[3:2]);
		u_host.wr(8'h47, 8'h00, 8'h01);
		for (int k = 0; k < 4; k++) begin
			cfg = {2'(k), ~2'(k)};
			u_host.wr(8'h2E, 8'h00, {4'h0, cfg});
			tick(2);
			chk_out({phase_limit_code, latchoff_delay_code}, cfg);
			chk_out(phase_limit_mv, mv_of(cfg[3:2]));
			chk_out(latchoff_delay_ms, 4'h4 + {cfg[1:0], 1'b0});
		end
		chk_reg(8'h2D, {4'h0, oc});
		u_host.wr(8'h2A, 8'h00, 8'h01);
		u_host.wr(8'h20, 8'h00, 8'h05);
		chk_reg(8'h20, 8'hFF);
		u_host.wr(8'h2A, 8'h00, 8'h00);
		chk_reg(8'h2A, 8'h01);
		sample(8'h06);
		chk_out(alert, 1'b0);
		// a frozen clock enable must drop the sample
		ce = 1'b0;
		sample(8'h00);
		ce = 1'b1;
		chk_reg(8'h26, 8'h06);
		// power cycle releases the lock
		@(negedge clk);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		chk_reg(8'h2A, 8'h00);
		u_host.wr(8'h20, 8'h00, 8'h05);
		chk_reg(8'h20, 8'h05);
		complete_run();
	end
endmodule
